// [shared/host_irq_pkg.sv]
package host_irq_pkg;

  // Register byte offsets on the APB window
  localparam logic [11:0] ENABLE_OFFSET = 12'h314;
  localparam logic [11:0] ISO_OR_OFFSET = 12'h318;
  localparam logic [11:0] INT_OR_OFFSET = 12'h31c;
  localparam logic [11:0] ASYNC_OR_OFFSET = 12'h320;
  localparam logic [11:0] ISO_AND_OFFSET = 12'h324;
  localparam logic [11:0] INT_AND_OFFSET = 12'h328;
  localparam logic [11:0] ASYNC_AND_OFFSET = 12'h32c;
  localparam logic [11:0] STATUS_OFFSET = 12'h330;

  // Bit positions of the enable, status and event layout
  localparam int OTG_BIT = 10;
  localparam int ISO_BIT = 9;
  localparam int ASYNC_BIT = 8;
  localparam int INT_XFER_BIT = 7;
  localparam int CLOCK_STABLE_BIT = 6;
  localparam int SUSPEND_BIT = 5;
  localparam int DMA_END_BIT = 3;
  localparam int FRAME_START_BIT = 1;

  // Descriptor lists, each with 32 descriptors
  localparam int LIST_COUNT = 3;
  localparam int DESC_COUNT = 32;
  localparam int ISO_LIST = 0;
  localparam int INT_LIST = 1;
  localparam int ASYNC_LIST = 2;
  localparam int MASK_COUNT = 6;

  // Reset values
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Bits that hold state in enable and status; reserved bits read zero
  localparam logic [31:0] LIVE_BITS = (32'h1 << OTG_BIT) | (32'h1 << ISO_BIT)
    | (32'h1 << ASYNC_BIT) | (32'h1 << INT_XFER_BIT) | (32'h1 << CLOCK_STABLE_BIT)
    | (32'h1 << SUSPEND_BIT) | (32'h1 << DMA_END_BIT) | (32'h1 << FRAME_START_BIT);

  // Shared layout of enable, status and event vectors
  typedef struct packed {
    logic [20:0] rsvd_hi;
    logic otg;
    logic iso;
    logic async_list;
    logic int_xfer;
    logic clock_stable;
    logic suspend;
    logic rsvd4;
    logic dma_end;
    logic rsvd2;
    logic frame_start;
    logic rsvd0;
  } irq_bits_t;

  // Whole state of the controller top
  typedef struct packed {
    irq_bits_t enable;
    irq_bits_t status;
    irq_bits_t evt_prev;
    logic [MASK_COUNT-1:0][31:0] masks;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } ctl_state_t;

  // State of one descriptor list matcher
  typedef struct packed {
    logic hit;
  } match_state_t;

endpackage

// [logic/list_match.sv]
`timescale 1ns/1ps
module list_match (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [31:0] done_in,
  input wire logic [31:0] or_mask_in,
  input wire logic [31:0] and_mask_in,
  output logic hit_out
);

  host_irq_pkg::match_state_t st;
  host_irq_pkg::match_state_t nx;
  logic or_cond;
  logic and_cond;

  // Any OR-selected descriptor done, or every AND-selected one done
  always_comb begin
    or_cond = |(done_in & or_mask_in);
    // Empty AND mask never fires, else it would be always true
    and_cond = (and_mask_in != 32'h0000_0000)
      && ((done_in & and_mask_in) == and_mask_in);
    nx = st;
    nx.hit = or_cond || and_cond;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign hit_out = st.hit;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_or_sel_hit: assert property (|(done_in & or_mask_in) |=> hit_out)
    else $error("OR-selected done descriptor gave no hit");
  a_and_all_hit: assert property ((and_mask_in != 32'h0000_0000)
    && ((done_in & and_mask_in) == and_mask_in) |=> hit_out)
    else $error("All AND-selected descriptors done but no hit");
  a_no_cond_quiet: assert property (!(|(done_in & or_mask_in))
    && ((done_in & and_mask_in) != and_mask_in) |=> !hit_out)
    else $error("Hit raised with neither condition met");

endmodule

// [logic/host_irq_ctl.sv]
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - OTG enable set: latched OTG events drive the interrupt line; clear: they do not
// - Isochronous enable gates interrupts from mask-selected isochronous descriptor completion
// - Async-list enable gates interrupts from mask-selected async descriptor completion
// - Bit 7 enables interrupts from mask-selected interrupt-type descriptor completion
// - Bit 6 enables an interrupt once internal clocks run stably
// - Bit 5 enables an interrupt when the host controller enters suspend
// - Bit 3 enables an interrupt when a DMA transfer completes
// - Bit 1 enables an interrupt at every start of frame
// - Isochronous OR mask: one bit per descriptor 0 to 31 joins OR condition
// - Isochronous OR mask is read-write at 0318h and resets to zero
// - Separate 32-bit isochronous AND mask selects descriptors forming an AND condition
// - Interrupt-type and async lists each have own OR and AND masks, reset zero
module host_irq_ctl (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic otg_latch_in,
  input wire logic [31:0] iso_done_in,
  input wire logic [31:0] int_done_in,
  input wire logic [31:0] async_done_in,
  input wire logic clock_stable_in,
  input wire logic suspend_entry_in,
  input wire logic dma_end_in,
  input wire logic frame_start_in,
  output logic irq_out
);

  host_irq_pkg::ctl_state_t st;
  host_irq_pkg::ctl_state_t nx;
  logic [host_irq_pkg::LIST_COUNT-1:0] list_hit;
  logic [host_irq_pkg::LIST_COUNT-1:0][31:0] list_done;
  host_irq_pkg::irq_bits_t evt_now;
  host_irq_pkg::irq_bits_t rise;
  host_irq_pkg::irq_bits_t clr;
  logic [31:0] rd_val;
  logic addr_ok;
  logic setup_phase;
  logic access_phase;

  assign list_done[host_irq_pkg::ISO_LIST] = iso_done_in;
  assign list_done[host_irq_pkg::INT_LIST] = int_done_in;
  assign list_done[host_irq_pkg::ASYNC_LIST] = async_done_in;

  // One matcher per descriptor list; masks live here, OR set then AND set
  genvar g;
  generate
    for (g = 0; g < host_irq_pkg::LIST_COUNT; g++) begin : gen_list
      list_match u_match (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .done_in(list_done[g]),
        .or_mask_in(st.masks[g]),
        .and_mask_in(st.masks[g + host_irq_pkg::LIST_COUNT]),
        .hit_out(list_hit[g])
      );
    end
  endgenerate

  // Read decode, combinational on the setup-phase address
  always_comb begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b0;
    if (paddr_in == host_irq_pkg::ENABLE_OFFSET) begin
      rd_val = st.enable;
      addr_ok = 1'b1;
    end else if (paddr_in == host_irq_pkg::STATUS_OFFSET) begin
      rd_val = st.status;
      addr_ok = 1'b1;
    end
    for (int i = 0; i < host_irq_pkg::MASK_COUNT; i++) begin
      if (paddr_in == host_irq_pkg::ISO_OR_OFFSET + 12'(4 * i)) begin
        rd_val = st.masks[i];
        addr_ok = 1'b1;
      end
    end
  end

  // Event sources in the enable layout; reserved positions never fire
  always_comb begin
    evt_now = '0;
    evt_now.otg = otg_latch_in;
    evt_now.iso = list_hit[host_irq_pkg::ISO_LIST];
    evt_now.async_list = list_hit[host_irq_pkg::ASYNC_LIST];
    evt_now.int_xfer = list_hit[host_irq_pkg::INT_LIST];
    evt_now.clock_stable = clock_stable_in;
    evt_now.suspend = suspend_entry_in;
    evt_now.dma_end = dma_end_in;
    evt_now.frame_start = frame_start_in;
    // Edge detect so a long level is one event, not a storm after each clear
    rise = host_irq_pkg::irq_bits_t'(evt_now & ~st.evt_prev);
  end

  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in && st.ready;

  // Next-state: APB slave, sticky status, line gating
  always_comb begin
    nx = st;
    clr = '0;
    nx.evt_prev = evt_now;
    nx.ready = 1'b0;
    nx.slverr = 1'b0;
    // Answer is prepared in setup so pready leaves a flop, one access cycle
    if (setup_phase) begin
      nx.ready = 1'b1;
      nx.slverr = !addr_ok;
      nx.rdata = pwrite_in ? 32'h0000_0000 : rd_val;
    end
    if (access_phase && pwrite_in && !st.slverr) begin
      if (paddr_in == host_irq_pkg::ENABLE_OFFSET) begin
        // Reserved positions are stored as zero whatever is written
        nx.enable = host_irq_pkg::irq_bits_t'(pwdata_in & host_irq_pkg::LIVE_BITS);
      end
      for (int i = 0; i < host_irq_pkg::MASK_COUNT; i++) begin
        if (paddr_in == host_irq_pkg::ISO_OR_OFFSET + 12'(4 * i)) begin
          nx.masks[i] = pwdata_in;
        end
      end
    end
    // Read clears only the bits returned, so a later event is not lost
    if (access_phase && !pwrite_in && paddr_in == host_irq_pkg::STATUS_OFFSET) begin
      clr = host_irq_pkg::irq_bits_t'(st.rdata);
    end
    // Set wins over the read clear in the same cycle
    nx.status = host_irq_pkg::irq_bits_t'((st.status & ~clr) | rise);
    nx.irq = |(st.status & st.enable);
  end

  // All control state from one register; enables come up zero
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st.enable <= host_irq_pkg::irq_bits_t'(host_irq_pkg::ENABLE_RESET);
      st.status <= host_irq_pkg::irq_bits_t'(host_irq_pkg::STATUS_RESET);
      st.evt_prev <= '0;
      st.masks <= {host_irq_pkg::MASK_COUNT{host_irq_pkg::MASK_RESET}};
      st.rdata <= 32'h0000_0000;
      st.ready <= 1'b0;
      st.slverr <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= nx;
    end
  end

  assign prdata_out = st.rdata;
  assign pready_out = st.ready;
  assign pslverr_out = st.slverr;
  assign irq_out = st.irq;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_otg_line_up: assert property (st.status.otg && st.enable.otg |=> irq_out)
    else $error("Enabled OTG status did not raise the line");

  a_iso_event_set: assert property (rise.iso |=> st.status.iso)
    else $error("Isochronous completion not recorded");

  a_async_line_path: assert property ($rose(list_hit[host_irq_pkg::ASYNC_LIST])
    && nx.enable.async_list |-> ##2 irq_out)
    else $error("Async completion did not reach the line in two cycles");

  a_int_line_up: assert property (st.status.int_xfer && st.enable.int_xfer
    |=> irq_out)
    else $error("Enabled interrupt-list status did not raise the line");

  a_clock_stable_line: assert property (rise.clock_stable && nx.enable.clock_stable
    |-> ##2 irq_out)
    else $error("Clock-stable event did not raise the line");

  a_suspend_line: assert property (rise.suspend && nx.enable.suspend
    |-> ##2 irq_out)
    else $error("Suspend entry did not raise the line");

  a_dma_end_line: assert property (rise.dma_end && nx.enable.dma_end
    |-> ##2 irq_out)
    else $error("DMA end did not raise the line");

  a_sof_line: assert property (rise.frame_start && nx.enable.frame_start
    |-> ##2 irq_out)
    else $error("Start of frame did not raise the line");

  a_masked_line_low: assert property ((st.status & st.enable) == 32'h0000_0000
    |=> !irq_out)
    else $error("Line high with no enabled status bit");

  a_iso_or_write: assert property (access_phase && pwrite_in
    && paddr_in == host_irq_pkg::ISO_OR_OFFSET
    |=> st.masks[host_irq_pkg::ISO_LIST] == $past(pwdata_in))
    else $error("Isochronous OR mask write not stored");

  a_enable_rsvd_zero: assert property ((st.enable & ~host_irq_pkg::LIVE_BITS)
    == 32'h0000_0000)
    else $error("Reserved enable bit holds a one");

  a_reset_quiet: assert property ($rose(resetn_in)
    |-> st.enable == host_irq_pkg::irq_bits_t'(host_irq_pkg::ENABLE_RESET)
    && !irq_out)
    else $error("Enables or line not clear after reset");

  a_status_read_clr: assert property (access_phase && !pwrite_in
    && paddr_in == host_irq_pkg::STATUS_OFFSET
    |=> (st.status & $past(st.rdata) & ~$past(rise)) == 32'h0000_0000)
    else $error("Status read did not clear returned bits");

  a_apb_one_wait: assert property (setup_phase |=> pready_out ##1 !pready_out)
    else $error("APB answer not exactly one access cycle");

  // Every source records its own rising edge in status, enabled or not
  a_otg_event_set: assert property (rise.otg |=> st.status.otg)
    else $error("OTG event not recorded");

  a_async_event_set: assert property (rise.async_list |=> st.status.async_list)
    else $error("Async completion not recorded");

  a_int_event_set: assert property (rise.int_xfer |=> st.status.int_xfer)
    else $error("Interrupt-list completion not recorded");

  a_clock_event_set: assert property (rise.clock_stable |=> st.status.clock_stable)
    else $error("Clock-stable event not recorded");

  a_suspend_event_set: assert property (rise.suspend |=> st.status.suspend)
    else $error("Suspend entry not recorded");

  a_dma_event_set: assert property (rise.dma_end |=> st.status.dma_end)
    else $error("DMA end not recorded");

  a_sof_event_set: assert property (rise.frame_start |=> st.status.frame_start)
    else $error("Start of frame not recorded");

  // A fresh matcher hit counts as one event in the same cycle
  a_iso_hit_rise: assert property ($rose(list_hit[host_irq_pkg::ISO_LIST])
    |-> rise.iso)
    else $error("Isochronous hit not seen as an event");

  a_async_hit_rise: assert property ($rose(list_hit[host_irq_pkg::ASYNC_LIST])
    |-> rise.async_list)
    else $error("Async hit not seen as an event");

  a_int_hit_rise: assert property ($rose(list_hit[host_irq_pkg::INT_LIST])
    |-> rise.int_xfer)
    else $error("Interrupt-list hit not seen as an event");

  // Bus answer only ever follows a setup cycle and lasts one cycle
  a_ready_after_setup: assert property (!setup_phase |=> !pready_out)
    else $error("Ready without a preceding setup");

  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("Error response without ready");

  a_err_one_cycle: assert property (pslverr_out |=> !pslverr_out)
    else $error("Error response held too long");

  a_bad_addr_err: assert property (setup_phase && !addr_ok |=> pslverr_out)
    else $error("Unmapped address not refused");

  a_good_addr_ok: assert property (setup_phase && addr_ok |=> !pslverr_out)
    else $error("Mapped address refused");

  a_write_rdata_zero: assert property (setup_phase && pwrite_in
    |=> prdata_out == 32'h0000_0000)
    else $error("Read data not zero after a write setup");

  // Read data is captured once per setup, so the master may sample late
  a_rdata_holds: assert property (!setup_phase |=> $stable(prdata_out))
    else $error("Read data changed outside a setup cycle");

  // Readback shows the register as it stood at setup
  a_enable_rdata: assert property (setup_phase && !pwrite_in
    && paddr_in == host_irq_pkg::ENABLE_OFFSET |=> prdata_out == $past(st.enable))
    else $error("Enable readback wrong");

  a_status_rdata: assert property (setup_phase && !pwrite_in
    && paddr_in == host_irq_pkg::STATUS_OFFSET |=> prdata_out == $past(st.status))
    else $error("Status readback wrong");

  a_enable_write: assert property (access_phase && pwrite_in && !st.slverr
    && paddr_in == host_irq_pkg::ENABLE_OFFSET
    |=> ((st.enable ^ $past(pwdata_in)) & host_irq_pkg::LIVE_BITS) == 32'h0000_0000)
    else $error("Enable write not stored");

  a_bad_write_ignored: assert property (access_phase && pwrite_in && st.slverr
    |=> st.enable == $past(st.enable) && st.masks == $past(st.masks))
    else $error("Refused write changed a register");

  // Registers change only by a bus write
  a_mask_hold: assert property (!(access_phase && pwrite_in) |=> $stable(st.masks))
    else $error("Mask changed without a write");

  a_enable_hold: assert property (!(access_phase && pwrite_in) |=> $stable(st.enable))
    else $error("Enable changed without a write");

  // Status bits fall only through a status read
  a_status_sticky: assert property (!(access_phase && !pwrite_in
    && paddr_in == host_irq_pkg::STATUS_OFFSET)
    |=> ($past(st.status) & ~st.status) == 32'h0000_0000)
    else $error("Status bit lost without a read");

  a_status_rsvd_zero: assert property ((st.status & ~host_irq_pkg::LIVE_BITS)
    == 32'h0000_0000)
    else $error("Reserved status bit holds a one");

  a_line_any_src: assert property ((st.status & st.enable) != 32'h0000_0000
    |=> irq_out)
    else $error("Enabled status did not raise the line");

  a_reset_regs_zero: assert property ($rose(resetn_in) |-> st.masks == '0
    && st.status == '0)
    else $error("Masks or status not clear after reset");

  // Each mask word stores a write and reads back at its own address
  for (genvar m = 0; m < host_irq_pkg::MASK_COUNT; m++) begin : gen_mask_chk
    a_mask_store: assert property (@(posedge clk_in) disable iff (!resetn_in)
      access_phase && pwrite_in
      && paddr_in == host_irq_pkg::ISO_OR_OFFSET + 12'(4 * m)
      |=> st.masks[m] == $past(pwdata_in))
      else $error("Mask write not stored");
    a_mask_rdata: assert property (@(posedge clk_in) disable iff (!resetn_in)
      setup_phase && !pwrite_in
      && paddr_in == host_irq_pkg::ISO_OR_OFFSET + 12'(4 * m)
      |=> prdata_out == $past(st.masks[m]))
      else $error("Mask readback wrong");
  end

endmodule

// [tb/tb_host_irq_enable_and_iso_mask.sv]
`timescale 1ns/1ps
module tb_host_irq_enable_and_iso_mask;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic otg_latch_in = 1'b0;
  logic [31:0] iso_done_in = 32'h0;
  logic [31:0] int_done_in = 32'h0;
  logic [31:0] async_done_in = 32'h0;
  logic clock_stable_in = 1'b0;
  logic suspend_entry_in = 1'b0;
  logic dma_end_in = 1'b0;
  logic frame_start_in = 1'b0;
  logic irq_out;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rdv;
  logic errv;
  // Source order: otg, iso, async, int, clock stable, suspend, dma end, frame start
  int bit_of[8] = '{host_irq_pkg::OTG_BIT, host_irq_pkg::ISO_BIT, host_irq_pkg::ASYNC_BIT,
    host_irq_pkg::INT_XFER_BIT, host_irq_pkg::CLOCK_STABLE_BIT, host_irq_pkg::SUSPEND_BIT,
    host_irq_pkg::DMA_END_BIT, host_irq_pkg::FRAME_START_BIT};
  logic [11:0] or_off[4] = '{12'h000, host_irq_pkg::ISO_OR_OFFSET,
    host_irq_pkg::ASYNC_OR_OFFSET, host_irq_pkg::INT_OR_OFFSET};
  logic [11:0] and_off[4] = '{12'h000, host_irq_pkg::ISO_AND_OFFSET,
    host_irq_pkg::ASYNC_AND_OFFSET, host_irq_pkg::INT_AND_OFFSET};
  logic [11:0] all_off[8] = '{host_irq_pkg::ENABLE_OFFSET, host_irq_pkg::ISO_OR_OFFSET,
    host_irq_pkg::INT_OR_OFFSET, host_irq_pkg::ASYNC_OR_OFFSET, host_irq_pkg::ISO_AND_OFFSET,
    host_irq_pkg::INT_AND_OFFSET, host_irq_pkg::ASYNC_AND_OFFSET, host_irq_pkg::STATUS_OFFSET};

  // Free-running 250 MHz clock
  always #2 clk_in = ~clk_in;

  host_irq_ctl i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .paddr_in(paddr_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .otg_latch_in(otg_latch_in), .iso_done_in(iso_done_in),
    .int_done_in(int_done_in), .async_done_in(async_done_in),
    .clock_stable_in(clock_stable_in), .suspend_entry_in(suspend_entry_in),
    .dma_end_in(dma_end_in), .frame_start_in(frame_start_in), .irq_out(irq_out));

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first keeps each strobe change in its own step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    paddr_in <= a;
    pwrite_in <= wr;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Wait as long as the slave takes; only the bench timeout ends it
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, errv);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, errv);
    check(rdv, exp);
  endtask

  task automatic set_done(input int i, input logic [31:0] v);
    case (i)
      1: iso_done_in <= v;
      2: async_done_in <= v;
      default: int_done_in <= v;
    endcase
  endtask

  task automatic set_src(input int i, input logic v);
    case (i)
      0: otg_latch_in <= v;
      1, 2, 3: set_done(i, v ? 32'h0000_0020 : 32'h0);
      4: clock_stable_in <= v;
      5: suspend_entry_in <= v;
      6: dma_end_in <= v;
      default: frame_start_in <= v;
    endcase
  endtask

  // Hold a source for six cycles, long enough for the done-map path too
  task automatic fire(input int i, input logic [31:0] exp_irq);
    set_src(i, 1'b1);
    repeat (6) @(posedge clk_in);
    set_src(i, 1'b0);
    check({31'h0, irq_out}, exp_irq);
  endtask

  // Cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("[ERR] %0t ns: timeout", $time);
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    check({31'h0, irq_out}, 32'h0);
    for (int k = 0; k < 8; k++) begin
      rd_chk(all_off[k], 32'h0);
    end
    // Mask registers hold distinct patterns, written back to back
    for (int k = 1; k < 7; k++) begin
      wr(all_off[k], 32'ha5c3_0f01 << k);
    end
    for (int k = 1; k < 7; k++) begin
      rd_chk(all_off[k], 32'ha5c3_0f01 << k);
    end
    wr(host_irq_pkg::ENABLE_OFFSET, host_irq_pkg::LIVE_BITS);
    rd_chk(host_irq_pkg::ENABLE_OFFSET, host_irq_pkg::LIVE_BITS);
    wr(host_irq_pkg::ENABLE_OFFSET, 32'h0);
    // Unmapped address is refused with zero data
    apb(1'b0, 12'h400, 32'h0, rdv, errv);
    check({errv, rdv[30:0]}, 32'h8000_0000);
    // Each source disabled, then enabled late, then enabled up front
    for (int i = 0; i < 8; i++) begin
      if (i >= 1 && i <= 3) begin
        wr(or_off[i], 32'h0000_0020);
        wr(and_off[i], 32'h0);
      end
      fire(i, 32'h0);
      wr(host_irq_pkg::ENABLE_OFFSET, 32'h1 << bit_of[i]);
      repeat (3) @(posedge clk_in);
      check({31'h0, irq_out}, 32'h1);
      rd_chk(host_irq_pkg::STATUS_OFFSET, 32'h1 << bit_of[i]);
      repeat (3) @(posedge clk_in);
      check({31'h0, irq_out}, 32'h0);
      rd_chk(host_irq_pkg::STATUS_OFFSET, 32'h0);
      fire(i, 32'h1);
      rd_chk(host_irq_pkg::STATUS_OFFSET, 32'h1 << bit_of[i]);
      wr(host_irq_pkg::ENABLE_OFFSET, 32'h0);
    end
    // Descriptor lists: unmasked done bit, partial and full AND set
    for (int i = 1; i < 4; i++) begin
      wr(and_off[i], 32'h0000_0003);
      wr(host_irq_pkg::ENABLE_OFFSET, 32'h1 << bit_of[i]);
      set_done(i, 32'h0000_0011);
      repeat (6) @(posedge clk_in);
      check({31'h0, irq_out}, 32'h0);
      set_done(i, 32'h0000_0013);
      repeat (6) @(posedge clk_in);
      set_done(i, 32'h0);
      check({31'h0, irq_out}, 32'h1);
      rd_chk(host_irq_pkg::STATUS_OFFSET, 32'h1 << bit_of[i]);
      repeat (3) @(posedge clk_in);
      check({31'h0, irq_out}, 32'h0);
      wr(host_irq_pkg::ENABLE_OFFSET, 32'h0);
    end
    conclude();
  end
endmodule
